/* File: ndft_pkg.sv */
package ndft_pkg;

   // ************************************************
   // Register word indices, byte address = 4 * index
   // ************************************************
   localparam logic [5:0] IDX_TX_LEN_LOW      = 6'h00;
   localparam logic [5:0] IDX_TX_LEN_HIGH     = 6'h01;
   localparam logic [5:0] IDX_RING_START      = 6'h02;
   localparam logic [5:0] IDX_RING_STOP       = 6'h03;
   localparam logic [5:0] IDX_RING_BOUNDARY   = 6'h04;
   localparam logic [5:0] IDX_RX_CURRENT      = 6'h05;
   localparam logic [5:0] IDX_LDMA_LOW        = 6'h06;
   localparam logic [5:0] IDX_LDMA_HIGH       = 6'h07;
   localparam logic [5:0] IDX_RSTART_LOW      = 6'h08;
   localparam logic [5:0] IDX_RSTART_HIGH     = 6'h09;
   localparam logic [5:0] IDX_RCOUNT_LOW      = 6'h0a;
   localparam logic [5:0] IDX_RCOUNT_HIGH     = 6'h0b;
   localparam logic [5:0] IDX_RADDR_LOW       = 6'h0c;
   localparam logic [5:0] IDX_RADDR_HIGH      = 6'h0d;
   localparam logic [5:0] IDX_STATION0        = 6'h0e;
   localparam logic [5:0] IDX_HASH0           = 6'h14;
   localparam logic [5:0] IDX_ALIGN_TALLY     = 6'h1c;
   localparam logic [5:0] IDX_CRC_TALLY       = 6'h1d;
   localparam logic [5:0] IDX_LOST_TALLY      = 6'h1e;
   localparam logic [5:0] IDX_LB_FIFO         = 6'h1f;
   localparam logic [5:0] IDX_CONTROL         = 6'h20;
   localparam logic [5:0] STATION_CNT         = 6'h06;
   localparam logic [5:0] HASH_CNT            = 6'h08;

   // ************************************************
   // Field positions, reset values, limits
   // ************************************************
   localparam int         HADDR_IDX_LSB       = 2;
   localparam int         HADDR_IDX_MSB       = 7;
   localparam int         HTRANS_ACTIVE_BIT   = 1;
   localparam int         CTRL_MONITOR_BIT    = 0;
   localparam logic [7:0] BYTE_ZERO           = 8'h00;
   localparam logic [7:0] PAGE_LAST_BYTE      = 8'hff;
   localparam logic [7:0] TALLY_MAX           = 8'hc0;
   localparam logic [31:0] CRC_POLY           = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT           = 32'hffffffff;
   localparam logic [5:0] DA_BITS             = 6'h30;
   localparam int         HASH_MSB            = 31;
   localparam int         HASH_LSB            = 26;

   // ************************************************
   // Types
   // ************************************************
   typedef logic [2:0] ndft_lb_ptr_t;

   typedef enum logic {PH_IDLE, PH_ACCESS} ndft_bus_ph_t;

   // Receive events from the MAC receive path
   typedef struct packed {
      logic pkt_start;
      logic byte_wr;
      logic pkt_ok;
      logic pkt_err;
      logic pkt_end;
      logic addr_ok;
      logic align_err;
      logic crc_err;
      logic no_buffer;
   } ndft_rx_evt_t;

   // Serial destination address bits
   typedef struct packed {
      logic first;
      logic valid;
      logic dest_addr_bit;
   } ndft_da_t;

   // Remote DMA transfer requests
   typedef struct packed {
      logic load;
      logic xfer;
      logic word;
   } ndft_rdma_req_t;

   // Loopback byte capture
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } ndft_lb_t;

   // Address filter result
   typedef struct packed {
      logic       done;
      logic       phys_match;
      logic       multicast;
      logic       hash_hit;
      logic [5:0] hash_idx;
   } ndft_filt_t;

   // DMA pointers toward the buffer memory
   typedef struct packed {
      logic [15:0] ldma_addr;
      logic        ldma_abort;
      logic        store_en;
      logic [15:0] rdma_addr;
      logic [15:0] rdma_count;
      logic        rdma_busy;
   } ndft_dma_t;

endpackage

/* File: ndft_lb_mem.sv */
`timescale 1ns/1ps
module ndft_lb_mem
(
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // Write port
   input  wire logic                  wr_en,
   input  wire ndft_pkg::ndft_lb_ptr_t wr_addr,
   input  wire logic [7:0]            wr_data,
   // Registered read port
   input  wire ndft_pkg::ndft_lb_ptr_t rd_addr,
   output logic [7:0]                 rd_data
);
   import ndft_pkg::*;

   typedef struct packed {
      logic [7:0][7:0] mem;
      logic [7:0]      rd_data;
   } ndft_mem_st_t;

   ndft_mem_st_t s_r;
   ndft_mem_st_t s_nxt;

   // Byte store and read register
   always_comb
   begin
      s_nxt = s_r;
      if (wr_en)
      begin
         s_nxt.mem[wr_addr] = wr_data;
      end
      s_nxt.rd_data = s_r.mem[rd_addr];
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign rd_data = s_r.rd_data;

endmodule

/* File: ndft_regs.sv */
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module ndft_regs
(
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   // Receive path events and address bits
   input  wire ndft_pkg::ndft_rx_evt_t rx_evt,
   input  wire ndft_pkg::ndft_da_t    da_in,
   // Remote DMA requests and loopback capture
   input  wire ndft_pkg::ndft_rdma_req_t rdma_req,
   input  wire ndft_pkg::ndft_lb_t    lb_in,
   // Results toward MAC and buffer memory
   output ndft_pkg::ndft_filt_t       filt_out,
   output ndft_pkg::ndft_dma_t        dma_out,
   output logic [15:0]                tx_length,
   output logic                       monitor_only_receive
);
   import ndft_pkg::*;

   typedef struct packed {
      ndft_bus_ph_t    ph;
      logic            hready;
      logic [31:0]     hrdata;
      logic [5:0]      idx;
      logic            wr;
      logic [15:0]     tx_len;
      logic [7:0]      ring_start;
      logic [7:0]      ring_stop;
      logic [7:0]      boundary;
      logic [7:0]      rx_current_page;
      logic [15:0]     rstart;
      logic [15:0]     rcount_reg;
      logic [5:0][7:0] station;
      logic [7:0][7:0] hash;
      logic [7:0]      t_align;
      logic [7:0]      t_crc;
      logic [7:0]      t_lost;
      logic            mon;
      ndft_lb_ptr_t    lb_wptr;
      ndft_lb_ptr_t    lb_rptr;
      logic [31:0]     crc;
      logic [47:0]     da_sr;
      logic [5:0]      da_cnt;
      ndft_filt_t      filt;
      ndft_dma_t       dma;
   } ndft_state_t;

   ndft_state_t s_r;
   ndft_state_t s_nxt;
   logic [7:0]  lb_rdata;

   // ************************************************
   // Helper functions
   // ************************************************

   // Following ring page with wrap to start
   function automatic logic [7:0] next_page(input logic [7:0] page,
                                            input logic [7:0] start,
                                            input logic [7:0] stop);
      logic [7:0] p1;
      p1 = page + 8'h01;
      return (p1 == stop) ? start : p1;
   endfunction

   // Saturating tally step
   function automatic logic [7:0] tally_inc(input logic [7:0] v);
      return (v >= TALLY_MAX) ? TALLY_MAX : v + 8'h01;
   endfunction

   // ************************************************
   // Loopback byte memory
   // ************************************************
   ndft_lb_mem u_lb_mem
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (lb_in.wr),
      .wr_addr (s_r.lb_wptr),
      .wr_data (lb_in.data),
      .rd_addr (s_r.lb_rptr),
      .rd_data (lb_rdata)
   );

   // ************************************************
   // Next state
   // ************************************************
   always_comb
   begin
      logic [5:0]  off_sta;
      logic [5:0]  off_hash;
      logic [7:0]  rd_byte;
      logic [7:0]  wd;
      logic [7:0]  np;
      logic [15:0] step;
      logic        evt_ok;
      logic [31:0] crc_v;
      logic        fb;
      logic [47:0] sr_v;
      off_sta  = s_r.idx - IDX_STATION0;
      off_hash = s_r.idx - IDX_HASH0;
      rd_byte  = BYTE_ZERO;
      wd       = hwdata[7:0];
      np       = BYTE_ZERO;
      step     = 16'h0001;
      evt_ok   = rx_evt.pkt_end && rx_evt.addr_ok;
      crc_v    = s_r.crc;
      fb       = 1'h0;
      sr_v     = s_r.da_sr;
      s_nxt    = s_r;
      s_nxt.dma.ldma_abort = 1'h0;
      s_nxt.filt.done      = 1'h0;

      // Read multiplexer, write-only registers read as zero
      case (s_r.idx)
         IDX_RING_START:    rd_byte = s_r.ring_start;
         IDX_RING_STOP:     rd_byte = s_r.ring_stop;
         IDX_RING_BOUNDARY: rd_byte = s_r.boundary;
         IDX_RX_CURRENT:    rd_byte = s_r.rx_current_page;
         IDX_LDMA_LOW:      rd_byte = s_r.dma.ldma_addr[7:0];
         IDX_LDMA_HIGH:     rd_byte = s_r.dma.ldma_addr[15:8];
         IDX_RADDR_LOW:     rd_byte = s_r.dma.rdma_addr[7:0];
         IDX_RADDR_HIGH:    rd_byte = s_r.dma.rdma_addr[15:8];
         IDX_ALIGN_TALLY:   rd_byte = s_r.t_align;
         IDX_CRC_TALLY:     rd_byte = s_r.t_crc;
         IDX_LOST_TALLY:    rd_byte = s_r.t_lost;
         IDX_LB_FIFO:       rd_byte = lb_rdata;
         IDX_CONTROL:       rd_byte = {7'h00, s_r.mon};
         default:
         begin
            if (s_r.idx >= IDX_STATION0 && s_r.idx < IDX_STATION0 + STATION_CNT)
            begin
               rd_byte = s_r.station[off_sta[2:0]];
            end
            else if (s_r.idx >= IDX_HASH0 && s_r.idx < IDX_HASH0 + HASH_CNT)
            begin
               rd_byte = s_r.hash[off_hash[2:0]];
            end
         end
      endcase

      // Bus phases: address capture, then one access cycle
      case (s_r.ph)
         PH_IDLE:
         begin
            if (hsel && htrans[HTRANS_ACTIVE_BIT] && hready)
            begin
               s_nxt.ph     = PH_ACCESS;
               s_nxt.hready = 1'h0;
               s_nxt.idx    = haddr[HADDR_IDX_MSB:HADDR_IDX_LSB];
               s_nxt.wr     = hwrite;
            end
         end
         PH_ACCESS:
         begin
            s_nxt.ph     = PH_IDLE;
            s_nxt.hready = 1'h1;
            s_nxt.hrdata = s_r.wr ? s_r.hrdata : {24'h000000, rd_byte};
            if (s_r.wr)
            begin
               case (s_r.idx)
                  IDX_TX_LEN_LOW:    s_nxt.tx_len[7:0]     = wd;
                  IDX_TX_LEN_HIGH:   s_nxt.tx_len[15:8]    = wd;
                  IDX_RING_START:    s_nxt.ring_start      = wd;
                  IDX_RING_STOP:     s_nxt.ring_stop       = wd;
                  IDX_RING_BOUNDARY: s_nxt.boundary        = wd;
                  IDX_RX_CURRENT:    s_nxt.rx_current_page            = wd;
                  IDX_RSTART_LOW:    s_nxt.rstart[7:0]     = wd;
                  IDX_RSTART_HIGH:   s_nxt.rstart[15:8]    = wd;
                  IDX_RCOUNT_LOW:    s_nxt.rcount_reg[7:0] = wd;
                  IDX_RCOUNT_HIGH:   s_nxt.rcount_reg[15:8] = wd;
                  IDX_CONTROL:       s_nxt.mon             = wd[CTRL_MONITOR_BIT];
                  default:
                  begin
                     if (s_r.idx >= IDX_STATION0 && s_r.idx < IDX_STATION0 + STATION_CNT)
                     begin
                        s_nxt.station[off_sta[2:0]] = wd;
                     end
                     else if (s_r.idx >= IDX_HASH0 && s_r.idx < IDX_HASH0 + HASH_CNT)
                     begin
                        s_nxt.hash[off_hash[2:0]] = wd;
                     end
                  end
               endcase
            end
            else
            begin
               // Read side effects: tally clear, port advance
               case (s_r.idx)
                  IDX_ALIGN_TALLY: s_nxt.t_align = BYTE_ZERO;
                  IDX_CRC_TALLY:   s_nxt.t_crc   = BYTE_ZERO;
                  IDX_LOST_TALLY:  s_nxt.t_lost  = BYTE_ZERO;
                  IDX_LB_FIFO:     s_nxt.lb_rptr = s_r.lb_rptr + 3'h1;
                  default:         s_nxt.t_lost  = s_nxt.t_lost;
               endcase
            end
         end
         default:
         begin
            s_nxt.ph     = PH_IDLE;
            s_nxt.hready = 1'h1;
         end
      endcase

      // Tallies, applied after the clear so an event wins
      if (evt_ok && rx_evt.align_err)
      begin
         s_nxt.t_align = tally_inc(s_nxt.t_align);
      end
      if (evt_ok && (rx_evt.crc_err || rx_evt.align_err))
      begin
         s_nxt.t_crc = tally_inc(s_nxt.t_crc);
      end
      if (rx_evt.no_buffer || (evt_ok && s_r.mon))
      begin
         s_nxt.t_lost = tally_inc(s_nxt.t_lost);
      end

      // Loopback capture keeps read pointer on the oldest byte
      if (lb_in.wr)
      begin
         s_nxt.lb_wptr = s_r.lb_wptr + 3'h1;
         s_nxt.lb_rptr = s_r.lb_wptr + 3'h1;
      end

      // Local DMA pointer and ring linking
      if (rx_evt.pkt_start || rx_evt.pkt_err)
      begin
         s_nxt.dma.ldma_addr = {s_r.rx_current_page, BYTE_ZERO};
      end
      else if (rx_evt.byte_wr && !s_r.mon)
      begin
         if (s_r.dma.ldma_addr[7:0] == PAGE_LAST_BYTE)
         begin
            np = next_page(s_r.dma.ldma_addr[15:8], s_r.ring_start, s_r.ring_stop);
            if (np == s_r.boundary)
            begin
               s_nxt.dma.ldma_abort = 1'h1;
            end
            else
            begin
               s_nxt.dma.ldma_addr = {np, BYTE_ZERO};
            end
         end
         else
         begin
            s_nxt.dma.ldma_addr = s_r.dma.ldma_addr + 16'h0001;
         end
      end
      if (rx_evt.pkt_ok)
      begin
         s_nxt.rx_current_page = (s_r.dma.ldma_addr[7:0] == BYTE_ZERO) ? s_r.dma.ldma_addr[15:8] :
                      next_page(s_r.dma.ldma_addr[15:8], s_r.ring_start, s_r.ring_stop);
      end
      s_nxt.dma.store_en = !s_nxt.mon;

      // Remote DMA
      if (rdma_req.word)
      begin
         step = 16'h0002;
      end
      if (rdma_req.load)
      begin
         s_nxt.dma.rdma_addr  = s_r.rstart;
         s_nxt.dma.rdma_count = s_r.rcount_reg;
      end
      else if (rdma_req.xfer && s_r.dma.rdma_busy)
      begin
         s_nxt.dma.rdma_addr  = s_r.dma.rdma_addr + step;
         s_nxt.dma.rdma_count = (s_r.dma.rdma_count < step) ? 16'h0000 :
                                s_r.dma.rdma_count - step;
      end
      s_nxt.dma.rdma_busy = (s_nxt.dma.rdma_count != 16'h0000);

      // Destination address: serial CRC and station compare
      if (da_in.valid && (da_in.first || s_r.da_cnt < DA_BITS))
      begin
         crc_v = da_in.first ? CRC_INIT : s_r.crc;
         fb    = crc_v[31] ^ da_in.dest_addr_bit;
         crc_v = {crc_v[30:0], 1'h0} ^ (fb ? CRC_POLY : 32'h00000000);
         sr_v  = {da_in.dest_addr_bit, s_r.da_sr[47:1]};
         s_nxt.crc    = crc_v;
         s_nxt.da_sr  = sr_v;
         s_nxt.da_cnt = da_in.first ? 6'h01 : s_r.da_cnt + 6'h01;
         if (s_nxt.da_cnt == DA_BITS)
         begin
            s_nxt.filt.done       = 1'h1;
            s_nxt.filt.hash_idx   = crc_v[HASH_MSB:HASH_LSB];
            s_nxt.filt.phys_match = (sr_v == s_r.station);
            s_nxt.filt.multicast  = sr_v[0];
            s_nxt.filt.hash_hit   = s_r.hash[crc_v[HASH_MSB:HASH_MSB-2]]
                                    [crc_v[HASH_LSB+2:HASH_LSB]];
         end
      end
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r        <= '0;
         s_r.ph     <= PH_IDLE;
         s_r.hready <= 1'h1;
         s_r.dma.store_en <= 1'h1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register, hresp tied to zero
   assign hreadyout            = s_r.hready;
   assign hrdata               = s_r.hrdata;
   assign hresp                = 1'h0;
   assign filt_out             = s_r.filt;
   assign dma_out              = s_r.dma;
   assign tx_length            = s_r.tx_len;
   assign monitor_only_receive = s_r.mon;

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic rd_crc_tally;
   logic rd_lost_tally;
   assign rd_crc_tally  = (s_r.ph == PH_ACCESS) && !s_r.wr && (s_r.idx == IDX_CRC_TALLY);
   assign rd_lost_tally = (s_r.ph == PH_ACCESS) && !s_r.wr && (s_r.idx == IDX_LOST_TALLY);

   tally_cap_a: assert property (s_r.t_align <= TALLY_MAX && s_r.t_crc <= TALLY_MAX
                                 && s_r.t_lost <= TALLY_MAX)
      else $error("tally above maximum");
   tally_clear_a: assert property (rd_crc_tally && !rx_evt.pkt_end |=> s_r.t_crc == 8'h00)
      else $error("tally not cleared by read");
   crc_align_a: assert property (rx_evt.pkt_end && rx_evt.addr_ok && rx_evt.align_err
                                 && !rd_crc_tally && s_r.t_crc < TALLY_MAX
                                 |=> s_r.t_crc == $past(s_r.t_crc) + 8'h01)
      else $error("alignment error missed in crc tally");
   lost_monitor_a: assert property (s_r.mon && rx_evt.pkt_end && rx_evt.addr_ok
                                    && !rd_lost_tally && s_r.t_lost < TALLY_MAX
                                    |=> s_r.t_lost == $past(s_r.t_lost) + 8'h01)
      else $error("monitor packet not counted");
   rdma_word_a: assert property (rdma_req.xfer && rdma_req.word && !rdma_req.load
                                 && s_r.dma.rdma_count >= 16'h0002
                                 |=> s_r.dma.rdma_addr == $past(s_r.dma.rdma_addr) + 16'h0002
                                 && s_r.dma.rdma_count == $past(s_r.dma.rdma_count) - 16'h0002)
      else $error("remote word step wrong");
   rdma_stop_a: assert property (!s_r.dma.rdma_busy && !rdma_req.load
                                 |=> $stable(s_r.dma.rdma_addr))
      else $error("remote DMA moved at zero count");
   ring_abort_a: assert property (rx_evt.byte_wr && !s_r.mon && !rx_evt.pkt_start
                                  && !rx_evt.pkt_err
                                  && s_r.dma.ldma_addr[7:0] == PAGE_LAST_BYTE
                                  && next_page(s_r.dma.ldma_addr[15:8], s_r.ring_start,
                                               s_r.ring_stop) == s_r.boundary
                                  |=> s_r.dma.ldma_abort && $stable(s_r.dma.ldma_addr))
      else $error("ring overflow not aborted");
   ldma_restore_a: assert property (rx_evt.pkt_err && !rx_evt.pkt_start
                                    |=> s_r.dma.ldma_addr == {$past(s_r.rx_current_page), 8'h00})
      else $error("local pointer not restored");
   bus_wait_a: assert property (s_r.ph == PH_IDLE && hsel && htrans[HTRANS_ACTIVE_BIT] && hready
                                |=> !hreadyout ##1 hreadyout)
      else $error("bus answer timing wrong");
   hash_pick_a: assert property (filt_out.done |-> filt_out.hash_hit ==
                                 s_r.hash[filt_out.hash_idx[5:3]][filt_out.hash_idx[2:0]]
                                 || $past(da_in.valid) == 1'h0)
      else $error("hash filter bit mismatch");

endmodule

/* File: ndft_far_model.sv */
`timescale 1ns/1ps
// ******************************
// Receive path and DMA requester
// ******************************
module ndft_far_model
(
   // Clock
   input  wire logic                hclk,
   // Pulses toward the block
   output ndft_pkg::ndft_rx_evt_t   rx_evt,
   output ndft_pkg::ndft_rdma_req_t rdma_req,
   output ndft_pkg::ndft_lb_t       lb_in,
   output ndft_pkg::ndft_da_t       da_in
);
   import ndft_pkg::*;
   // Quiet levels at time zero
   initial
   begin
      rx_evt   = '0;
      rdma_req = '0;
      lb_in    = '0;
      da_in    = '0;
   end
   // One-cycle pulse, then a quiet cycle
   task automatic send(input logic [8:0] e, input logic [2:0] r, input logic [8:0] l);
      @(posedge hclk);
      rx_evt   <= e;
      rdma_req <= r;
      lb_in    <= l;
      @(posedge hclk);
      rx_evt   <= '0;
      rdma_req <= '0;
      lb_in    <= {1'b0, ~l[7:0]}; // Stale byte inverted
      @(posedge hclk);
   endtask
   // Destination address, bit 0 first, then a quiet cycle
   task automatic send_da(input logic [47:0] a);
      for (int i = 0; i < 48; i++)
      begin
         @(posedge hclk);
         da_in <= {(i == 0), 1'b1, a[i]};
      end
      @(posedge hclk);
      da_in <= '0;
      @(posedge hclk);
   endtask
endmodule

/* File: nic_dma_filter_tally_regs_tb_top.sv */
`timescale 1ns/1ps
// ******************************
// Register bank testbench
// ******************************
module nic_dma_filter_tally_regs_tb_top;
   import ndft_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, monitor_only_receive;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [15:0] tx_length;
   ndft_rx_evt_t rx_evt;
   ndft_da_t    da_in;
   ndft_rdma_req_t rdma_req;
   ndft_lb_t    lb_in;
   ndft_dma_t   dma_out;
   ndft_filt_t  filt_out;
   int          num_errors = 0;
   int          n_checks = 0;
   ndft_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .rx_evt(rx_evt), .da_in(da_in),
      .rdma_req(rdma_req), .lb_in(lb_in), .filt_out(filt_out), .dma_out(dma_out),
      .tx_length(tx_length), .monitor_only_receive(monitor_only_receive));
   ndft_far_model fm_u (.hclk(hclk), .rx_evt(rx_evt), .rdma_req(rdma_req), .lb_in(lb_in),
      .da_in(da_in));
   // Clock
   initial hclk = 1'b0;
   always #10 hclk = ~hclk;
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
         num_errors++;
      end
   endtask
   // One AHB single transfer, waits on ready
   task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, i, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask
   task automatic rd(input logic [5:0] i, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, i, 8'h00, q);
      chk(q, {24'h0, e});
   endtask
   task automatic finish_test;
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (6000) @(posedge hclk);
      num_errors++;
      finish_test;
   end
   // Test sequence
   initial
   begin
      {hsel, hwrite, haddr, hwdata, htrans, hresetn} = '0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      wr(IDX_TX_LEN_LOW, 8'hee);
      wr(IDX_TX_LEN_HIGH, 8'hff);
      chk({16'h0, tx_length}, 32'hffee);
      for (int k = 0; k < 14; k++)
      begin
         wr(IDX_STATION0 + 6'(k), 8'h5a ^ 8'(k));
         rd(IDX_STATION0 + 6'(k), 8'h5a ^ 8'(k));
      end
      wr(IDX_RING_START, 8'h40);
      wr(IDX_RING_STOP, 8'h48);
      wr(IDX_RING_BOUNDARY, 8'h40);
      wr(IDX_RX_CURRENT, 8'h40);
      rd(IDX_RING_STOP, 8'h48);
      fm_u.send(9'h100, 3'h0, 9'h0);
      repeat (3) fm_u.send(9'h080, 3'h0, 9'h0);
      rd(IDX_LDMA_HIGH, 8'h40);
      rd(IDX_LDMA_LOW, 8'h03);
      fm_u.send(9'h020, 3'h0, 9'h0);
      chk({16'h0, dma_out.ldma_addr}, 32'h4000);
      wr(IDX_RING_BOUNDARY, 8'h41);
      repeat (256) fm_u.send(9'h080, 3'h0, 9'h0);
      chk({16'h0, dma_out.ldma_addr}, 32'h40ff);
      fm_u.send_da(48'h5f5e59585b5a);
      chk({30'h0, filt_out.phys_match, filt_out.multicast}, 32'h2);
      fm_u.send_da(48'h5f5e59585b5b);
      chk({30'h0, filt_out.phys_match, filt_out.multicast}, 32'h1);
      wr(IDX_RSTART_LOW, 8'hfe);
      wr(IDX_RSTART_HIGH, 8'h12);
      wr(IDX_RCOUNT_LOW, 8'h03);
      wr(IDX_RCOUNT_HIGH, 8'h00);
      fm_u.send(9'h0, 3'b100, 9'h0);
      fm_u.send(9'h0, 3'b011, 9'h0);
      chk({16'h0, dma_out.rdma_count}, 32'h1);
      rd(IDX_RADDR_LOW, 8'h00);
      rd(IDX_RADDR_HIGH, 8'h13);
      fm_u.send(9'h0, 3'b010, 9'h0);
      fm_u.send(9'h0, 3'b011, 9'h0);
      chk({dma_out.rdma_addr, dma_out.rdma_count}, 32'h13010000);
      fm_u.send(9'h01c, 3'h0, 9'h0);
      fm_u.send(9'h01a, 3'h0, 9'h0);
      fm_u.send(9'h014, 3'h0, 9'h0);
      rd(IDX_ALIGN_TALLY, 8'h01);
      rd(IDX_CRC_TALLY, 8'h02);
      rd(IDX_ALIGN_TALLY, 8'h00);
      repeat (200) fm_u.send(9'h001, 3'h0, 9'h0);
      rd(IDX_LOST_TALLY, TALLY_MAX);
      rd(IDX_LOST_TALLY, 8'h00);
      wr(IDX_CONTROL, 8'h01);
      chk({30'h0, monitor_only_receive, dma_out.store_en}, 32'h2);
      fm_u.send(9'h018, 3'h0, 9'h0);
      rd(IDX_LOST_TALLY, 8'h01);
      for (int k = 0; k < 10; k++)
         fm_u.send(9'h0, 3'h0, {1'b1, 8'h10 + 8'(k)});
      for (int k = 0; k < 8; k++)
         rd(IDX_LB_FIFO, 8'h12 + 8'(k));
      rd(6'h3f, 8'h00);
      rd(IDX_RCOUNT_LOW, 8'h00);
      finish_test;
   end
endmodule
